// *** pgac_pkg.sv ***
package pgac_pkg;
  // Register indices, used directly as port addresses.
  localparam logic [4:0] PGAC_ADDR_PUMP    = 5'h0e;
  localparam logic [4:0] PGAC_ADDR_AMP     = 5'h13;
  localparam logic [4:0] PGAC_ADDR_START   = 5'h14;
  localparam logic [4:0] PGAC_ADDR_CTRL    = 5'h1f;
  // Field positions.
  localparam int PGAC_UP_LSB    = 2;
  localparam int PGAC_DN_LSB    = 7;
  localparam int PGAC_COARSE_LSB = 0;
  localparam int PGAC_CODE_LSB  = 3;
  localparam int PGAC_START_LSB = 0;
  localparam int PGAC_OVR_BIT   = 0;
  localparam int PGAC_CALEN_BIT = 1;
  localparam int PGAC_BUSY_BIT  = 2;
  // Reset values.
  localparam logic [4:0]  PGAC_UP_RST     = 5'h03;
  localparam logic [4:0]  PGAC_DN_RST     = 5'h03;
  localparam logic [1:0]  PGAC_COARSE_RST = 2'h1;
  localparam logic [8:0]  PGAC_START_RST  = 9'h12c;
  localparam logic [8:0]  PGAC_CODE_RST   = 9'h12c;
  localparam logic [15:0] PGAC_PUMP_HI_RST  = 16'h0000;
  localparam logic [15:0] PGAC_AMP_HI_RST   = 16'h0000;
  localparam logic [15:0] PGAC_START_HI_RST = 16'h0000;
  // Coarse gain in quarter steps: 1.0, 2.0, 1.5, 2.5.
  localparam logic [3:0] PGAC_GAIN_Q0 = 4'h4;
  localparam logic [3:0] PGAC_GAIN_Q1 = 4'h8;
  localparam logic [3:0] PGAC_GAIN_Q2 = 4'h6;
  localparam logic [3:0] PGAC_GAIN_Q3 = 4'ha;
  typedef enum logic [2:0] {
    PGAC_IDLE = 3'b001,
    PGAC_STEP = 3'b010,
    PGAC_DONE = 3'b100
  } pgac_state_e;
endpackage : pgac_pkg

// *** pgac_cal_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Handshake between the register bank and the amplitude search engine.
interface pgac_cal_if;
  logic       start;
  logic [8:0] start_code;
  logic       busy;
  logic       done;
  logic [8:0] code;
  modport bank (output start, output start_code, input busy, input done, input code);
  modport eng  (input start, input start_code, output busy, output done, output code);
endinterface : pgac_cal_if
`default_nettype wire

// *** pgac_cal_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
// Steps the amplitude code upward from the start code until the oscillator reports target amplitude.
module pgac_cal_engine
  import pgac_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // Amplitude comparator from the oscillator.
  input  wire logic   amp_reached_in,
  // Bank side.
  pgac_cal_if.eng     cal
);
  pgac_state_e state_q, state_d;
  logic [8:0]  code_q,  code_d;

  // Next state: load start code, then step up one code per cycle until target or top of range.
  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    case (state_q)
      PGAC_IDLE: if (cal.start) begin
        code_d  = cal.start_code; // RQ12
        state_d = PGAC_STEP;
      end
      PGAC_STEP: if (amp_reached_in || code_q == 9'h1ff) begin
        state_d = PGAC_DONE;
      end else begin
        code_d = code_q + 9'h001; // RQ8
      end
      PGAC_DONE: state_d = PGAC_IDLE;
      default:   state_d = PGAC_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= PGAC_IDLE;
      code_q  <= PGAC_START_RST;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
    end
  end

  assign cal.busy = (state_q == PGAC_STEP);
  assign cal.done = (state_q == PGAC_DONE);
  assign cal.code = code_q;

  step_up_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PGAC_STEP && !amp_reached_in && code_q != 9'h1ff) |=> code_q == $past(code_q) + 9'h001) // RQ8
    else $error("search did not step up");
  load_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PGAC_IDLE && cal.start) |=> (code_q == $past(cal.start_code) && cal.busy)) // RQ12
    else $error("search did not load start code");
  cal_run_c: cover property (@(posedge clk_in) disable iff (rst_in) cal.busy ##3 cal.done);
endmodule : pgac_cal_engine
`default_nettype wire

// *** pgac_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - The pump register holds a five-bit up-current field at bits 6:2 that resets to 3.
// RQ2 - Each up-current bit drives its own current leg, so every combination is legal.
// RQ3 - The coarse gain field at bits 1:0 resets to 1 and selects gain 1, 2, 1.5 or 2.5.
// RQ4 - Software should use only coarse gain codes 0 or 2 to keep lock detect accurate.
// RQ5 - With override set the amplitude code field at bits 11:3 drives the oscillator and calibration is unused.
// RQ6 - Software writes only amplitude codes 250 to 450.
// RQ7 - The calibration start field at bits 8:0 resets to 300 and is where the search begins.
// RQ8 - Calibration steps the amplitude code upward until target, so a closer start is faster.
// RQ9 - Software keeps the start value within 250 to 450.
// RQ10 - Software writes default values into the unnamed bit ranges, which are stored as written in the pump, amplitude and start registers.
// RQ11 - The pump register holds a five-bit down-current field at bits 11:7 that resets to 3.
// RQ12 - With override clear and calibration enabled, the engine starts from the start field and writes back its result; a same-cycle amplitude write wins.
module pgac_regs
  import pgac_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port.
  input  wire logic [4:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // Oscillator and pump controls.
  input  wire logic        amp_reached_in,
  output logic      [4:0]  pump_up_leg_out,
  output logic      [4:0]  pump_down_leg_out,
  output logic      [3:0]  pump_gain_quarters_out,
  output logic      [8:0]  osc_amp_code_out,
  output logic             amp_cal_busy_out
);
  logic [15:0] pump_q, pump_d;
  logic [15:0] amp_q, amp_d;
  logic [15:0] start_q, start_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [15:0] rdata_q, rdata_d;
  logic        go_q, go_d;
  pgac_cal_if  cal ();

  // Maps a coarse gain code to the gain in quarter steps.
  function automatic logic [3:0] gain_q(input logic [1:0] c);
    case (c)
      2'h0:    gain_q = PGAC_GAIN_Q0;
      2'h1:    gain_q = PGAC_GAIN_Q1;
      2'h2:    gain_q = PGAC_GAIN_Q2;
      default: gain_q = PGAC_GAIN_Q3;
    endcase
  endfunction : gain_q

  pgac_cal_engine u_eng (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .amp_reached_in (amp_reached_in),
    .cal            (cal.eng)
  );

  // Register writes; a finished search with override clear writes its code back unless software writes the amplitude register the same cycle.
  always_comb begin
    pump_d  = pump_q;
    amp_d   = amp_q;
    start_d = start_q;
    ctrl_d  = ctrl_q;
    go_d    = 1'b0;
    if (cal.done && !ctrl_q[PGAC_OVR_BIT]) begin
      amp_d[PGAC_CODE_LSB +: 9] = cal.code; // RQ12
    end
    if (wr_in) begin
      case (addr_in)
        PGAC_ADDR_PUMP:  pump_d  = wdata_in; // RQ1 RQ3 RQ11 RQ10
        PGAC_ADDR_AMP:   amp_d   = wdata_in; // RQ5 RQ10
        PGAC_ADDR_START: start_d = wdata_in; // RQ7 RQ10
        PGAC_ADDR_CTRL: begin
          ctrl_d = wdata_in[1:0];
          // A write with enable set and override clear launches one search unless the engine is busy.
          go_d = wdata_in[PGAC_CALEN_BIT] && !wdata_in[PGAC_OVR_BIT] && !cal.busy; // RQ12
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        PGAC_ADDR_PUMP:  rdata_d = pump_q;
        PGAC_ADDR_AMP:   rdata_d = amp_q;
        PGAC_ADDR_START: rdata_d = start_q;
        PGAC_ADDR_CTRL:  rdata_d = {13'h0000, cal.busy, ctrl_q};
        default:         rdata_d = 16'h0000;
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pump_q  <= PGAC_PUMP_HI_RST | {4'h0, PGAC_DN_RST, PGAC_UP_RST, PGAC_COARSE_RST}; // RQ1 RQ3 RQ11
      amp_q   <= PGAC_AMP_HI_RST | {4'h0, PGAC_CODE_RST, 3'h0};
      start_q <= PGAC_START_HI_RST | {7'h00, PGAC_START_RST}; // RQ7
      ctrl_q  <= 2'h0;
      rdata_q <= 16'h0000;
      go_q    <= 1'b0;
    end else begin
      pump_q  <= pump_d;
      amp_q   <= amp_d;
      start_q <= start_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      go_q    <= go_d;
    end
  end

  // Engine launch uses the start field; override blocks any launch.
  assign cal.start      = go_q && !ctrl_q[PGAC_OVR_BIT]; // RQ5
  assign cal.start_code = start_q[PGAC_START_LSB +: 9]; // RQ7

  // Pump legs are the raw field bits, one leg per bit, so any mix is valid.
  assign pump_up_leg_out        = pump_q[PGAC_UP_LSB +: 5]; // RQ2
  assign pump_down_leg_out      = pump_q[PGAC_DN_LSB +: 5]; // RQ11
  assign pump_gain_quarters_out = gain_q(pump_q[PGAC_COARSE_LSB +: 2]); // RQ3
  // While searching with override clear the engine code drives the oscillator; otherwise the stored field does.
  assign osc_amp_code_out = (cal.busy && !ctrl_q[PGAC_OVR_BIT]) ? cal.code : amp_q[PGAC_CODE_LSB +: 9]; // RQ5
  assign amp_cal_busy_out = cal.busy;
  assign rdata_out        = rdata_q;

  reset_vals_a: assert property (@(posedge clk_in) disable iff (rst_in) $past(rst_in) |->
    (pump_q[6:2] == 5'h03 && pump_q[11:7] == 5'h03 && pump_q[1:0] == 2'h1 && start_q[8:0] == 9'h12c)) // RQ1
    else $error("reset values wrong");
  up_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_in && addr_in == PGAC_ADDR_PUMP) |=> pump_up_leg_out == $past(wdata_in[6:2])) // RQ2
    else $error("up current not written");
  dn_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_in && addr_in == PGAC_ADDR_PUMP) |=> pump_down_leg_out == $past(wdata_in[11:7])) // RQ11
    else $error("down current not written");
  gain_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
    pump_gain_quarters_out == (pump_q[1:0] == 2'h0 ? 4'h4 : pump_q[1:0] == 2'h1 ? 4'h8 :
                               pump_q[1:0] == 2'h2 ? 4'h6 : 4'ha)) // RQ3
    else $error("coarse gain map wrong");
  ovr_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_q[PGAC_OVR_BIT] |-> (osc_amp_code_out == amp_q[11:3] && !cal.start)) // RQ5
    else $error("override not honoured");
  start_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_in && addr_in == PGAC_ADDR_START) |=> cal.start_code == $past(wdata_in[8:0])) // RQ7
    else $error("start code not written");
  write_back_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cal.done && !ctrl_q[PGAC_OVR_BIT] && !wr_in) |=> amp_q[11:3] == $past(cal.code)) // RQ12
    else $error("calibrated code not written back");
  read_back_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == PGAC_ADDR_START && !wr_in) |=> rdata_out == $past(start_q)) // RQ10
    else $error("start register read wrong");
  ovr_run_c: cover property (@(posedge clk_in) disable iff (rst_in) ctrl_q[PGAC_OVR_BIT] && wr_in);
  cal_go_c:  cover property (@(posedge clk_in) disable iff (rst_in) cal.start ##[1:600] cal.done);
  gain_c:    cover property (@(posedge clk_in) disable iff (rst_in) pump_q[1:0] == 2'h3);
endmodule : pgac_regs
`default_nettype wire

// *** test_pump_gain_and_amplitude_cal_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pump_gain_and_amplitude_cal_regs;
  import pgac_pkg::*;
  logic        clk_in         = 1'b0;
  logic        rst_in         = 1'b1;
  logic [4:0]  addr_in        = 5'h00;
  logic [15:0] wdata_in       = 16'h0000;
  logic        wr_in          = 1'b0;
  logic        rd_in          = 1'b0;
  logic        amp_reached_in = 1'b0;
  logic [15:0] rdata_out;
  logic [4:0]  up_leg;
  logic [4:0]  dn_leg;
  logic [3:0]  gain_q;
  logic [8:0]  osc_code;
  logic        busy;
  logic [15:0] rv;
  logic [3:0]  gq [4] = '{4'h4, 4'h8, 4'h6, 4'ha};
  int          error_cnt = 0;
  int          n_checks  = 0;

  // Free-running 250 MHz clock.
  always #2 clk_in = ~clk_in;

  pgac_regs uut (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .addr_in                (addr_in),
    .wdata_in               (wdata_in),
    .wr_in                  (wr_in),
    .rd_in                  (rd_in),
    .rdata_out              (rdata_out),
    .amp_reached_in         (amp_reached_in),
    .pump_up_leg_out        (up_leg),
    .pump_down_leg_out      (dn_leg),
    .pump_gain_quarters_out (gain_q),
    .osc_amp_code_out       (osc_code),
    .amp_cal_busy_out       (busy)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; the port never stalls, so no wait is needed.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  task automatic t_reset;
    #1;
    chk(16'(up_leg), 16'h0003);
    chk(16'(dn_leg), 16'h0003);
    chk(16'(gain_q), 16'h0008);
    chk(16'(busy), 16'h0000);
    rd(PGAC_ADDR_PUMP, rv);
    chk(rv, 16'h018d);
    rd(PGAC_ADDR_START, rv);
    chk(rv, 16'h012c);
    rd(5'h01, rv);
    chk(rv, 16'h0000);
  endtask : t_reset

  // Every coarse code, with up and down legs in scattered bit patterns.
  task automatic t_pump;
    logic [4:0]  up;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      up = 5'(i * 9 + 1);
      d  = {4'ha, ~up, up, 2'(i)};
      wr(PGAC_ADDR_PUMP, d);
      @(posedge clk_in);
      #1;
      chk(16'(up_leg), 16'(up));
      chk(16'(dn_leg), 16'(5'(~up)));
      chk(16'(gain_q), 16'(gq[i]));
      rd(PGAC_ADDR_PUMP, rv);
      chk(rv, d);
    end
    // Leave the pump on a recommended coarse code with matched legs for the rest of the run.
    wr(PGAC_ADDR_PUMP, 16'h018e);
    @(posedge clk_in);
    #1;
    chk(16'(gain_q), 16'h0006);
  endtask : t_pump

  // A launch request with override set must leave the written code in charge.
  task automatic t_ovr;
    wr(PGAC_ADDR_AMP, 16'h0c80);
    wr(PGAC_ADDR_CTRL, 16'h0003);
    repeat (4) @(posedge clk_in);
    #1;
    chk(16'(busy), 16'h0000);
    chk(16'(osc_code), 16'h0190);
    wr(PGAC_ADDR_CTRL, 16'h0000);
  endtask : t_ovr

  // Search starts at the start field, climbs, and writes its result back.
  task automatic t_cal;
    wr(PGAC_ADDR_START, 16'h0104);
    wr(PGAC_ADDR_CTRL, 16'h0002);
    @(posedge clk_in);
    #1;
    chk(16'(busy), 16'h0001);
    chk(16'(osc_code), 16'h0104);
    repeat (5) @(posedge clk_in);
    #1;
    chk(16'(osc_code), 16'h0109);
    @(posedge clk_in);
    amp_reached_in <= 1'b1;
    for (int k = 0; k < 8 && busy !== 1'b0; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk(16'(busy), 16'h0000);
    @(posedge clk_in);
    amp_reached_in <= 1'b0;
    rd(PGAC_ADDR_AMP, rv);
    chk(rv, 16'h0850);
    chk(16'(osc_code), 16'h010a);
  endtask : t_cal

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_pump();
    t_ovr();
    t_cal();
    print_verdict();
  end

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule : test_pump_gain_and_amplitude_cal_regs
`default_nettype wire
